// ===== anp_pkg.sv
// Package: register map, field layout and reset values of the next page transmit block
package anp_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned NPT_INDEX    = 32'h0000_0007;
  localparam int unsigned PAGE_STS_IDX = 32'h0000_0008;
  localparam logic [7:0]  NPT_ADDR     = 8'h1C;
  localparam logic [7:0]  PAGE_STS_ADDR = 8'h20;
  localparam int unsigned ADDR_W       = 8;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int unsigned MORE_PAGES_BIT = 15;
  localparam int unsigned RSVD_BIT       = 14;
  localparam int unsigned MSG_PAGE_BIT   = 13;
  localparam int unsigned ACK_BIT        = 12;
  localparam int unsigned TOGGLE_BIT     = 11;
  localparam int unsigned CODE_MSB       = 10;
  localparam int unsigned CODE_W         = 11;
  localparam int unsigned PAGE_RX_BIT    = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0]  NPT_RESET  = 16'h2001;
  localparam logic [10:0]  CODE_RESET = 11'h001;
  localparam logic         MSG_RESET  = 1'b1;

  typedef enum logic [1:0] {
    ANP_IDLE,
    ANP_ACK,
    ANP_GAP
  } anp_bus_state_t;

endpackage : anp_pkg

// ===== anp_page_if.sv
// Interface: page-sent strobe, sent toggle bit and toggle between register file and toggle tracker
`timescale 1ns/1ps
interface anp_page_if;
  logic        sent;
  logic        sent_toggle;
  logic        toggle;

  modport regs (input toggle, output sent, output sent_toggle);
  modport trk  (output toggle, input sent, input sent_toggle);
endinterface : anp_page_if

// ===== anp_toggle_trk.sv
// Module: tracks the toggle bit of the next page to transmit
`timescale 1ns/1ps
module anp_toggle_trk (
  input  wire logic clk_i,
  input  wire logic rst_i,
  anp_page_if.trk   pg
);

  typedef struct packed {
    logic toggle;
  } anp_trk_state_t;

  anp_trk_state_t s_q;
  anp_trk_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (pg.sent) begin
      s_d.toggle = ~pg.sent_toggle;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pg.toggle = s_q.toggle;

endmodule : anp_toggle_trk

// ===== anp_next_page_tx.sv
// Module: next page transmit register with Wishbone slave
`timescale 1ns/1ps
module anp_next_page_tx (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        page_sent_i,
  input  wire logic        page_rx_i,
  output logic      [15:0] tx_page_o
);

  anp_page_if pg ();

  typedef struct packed {
    anp_pkg::anp_bus_state_t st;
    logic [31:0]             rdata;
    logic                    more_pages_flag;
    logic                    message_page_flag;
    logic                    will_comply_ack;
    logic [10:0]             code;
    logic                    page_rx;
    logic [15:0]             tx_page;
  } anp_state_t;

  anp_state_t s_q;
  anp_state_t s_d;
  logic [15:0] reg_val;
  logic        hit_npt;
  logic        hit_sts;
  logic        req;

  // ****************************************************************
  // Register value
  // ****************************************************************
  always_comb begin
    reg_val = {s_q.more_pages_flag, 1'b0, s_q.message_page_flag,
               s_q.will_comply_ack, pg.toggle, s_q.code};
  end

  assign pg.sent        = page_sent_i;
  assign pg.sent_toggle = s_q.tx_page[anp_pkg::TOGGLE_BIT];

  anp_toggle_trk u_trk (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pg    (pg)
  );

  // ****************************************************************
  // Bus and field update
  // ****************************************************************
  always_comb begin
    s_d     = s_q;
    req     = cyc_i && stb_i;
    hit_npt = (adr_i == anp_pkg::NPT_ADDR);
    hit_sts = (adr_i == anp_pkg::PAGE_STS_ADDR);
    s_d.tx_page = reg_val;
    case (s_q.st)
      anp_pkg::ANP_IDLE: begin
        if (req) begin
          s_d.st    = anp_pkg::ANP_ACK;
          s_d.rdata = 32'h0000_0000;
          if (!we_i && hit_npt) begin
            s_d.rdata = {16'h0000, reg_val};
          end
          if (!we_i && hit_sts) begin
            s_d.rdata = {31'h0000_0000, s_q.page_rx};
          end
        end
      end
      anp_pkg::ANP_ACK: begin
        s_d.st = anp_pkg::ANP_GAP;
        // Write lands on the edge at which the master sees ack
        if (req && we_i && hit_npt && sel_i[1]) begin
          s_d.more_pages_flag   = dat_i[anp_pkg::MORE_PAGES_BIT];
          s_d.message_page_flag = dat_i[anp_pkg::MSG_PAGE_BIT];
          s_d.will_comply_ack   = dat_i[anp_pkg::ACK_BIT];
          s_d.code[10:8]        = dat_i[anp_pkg::CODE_MSB:8];
        end
        if (req && we_i && hit_npt && sel_i[0]) begin
          s_d.code[7:0] = dat_i[7:0];
        end
      end
      anp_pkg::ANP_GAP: begin
        if (!req) begin
          s_d.st = anp_pkg::ANP_IDLE;
        end
      end
      default: begin
        s_d.st = anp_pkg::ANP_IDLE;
      end
    endcase
    // Arrival wins over the clear of a read in the same cycle
    if (s_q.st == anp_pkg::ANP_ACK && !we_i && hit_sts) begin
      s_d.page_rx = 1'b0;
    end
    if (page_rx_i) begin
      s_d.page_rx = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q                   <= '0;
      s_q.st                <= anp_pkg::ANP_IDLE;
      s_q.message_page_flag <= anp_pkg::MSG_RESET;
      s_q.code              <= anp_pkg::CODE_RESET;
      s_q.tx_page           <= anp_pkg::NPT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign dat_o     = s_q.rdata;
  assign ack_o     = (s_q.st == anp_pkg::ANP_ACK);
  assign tx_page_o = s_q.tx_page;

endmodule : anp_next_page_tx

// ===== anp_next_page_tx_chk.sv
// Checker for the next page transmit block
`timescale 1ns/1ps
module anp_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        page_sent_i,
  input wire logic        page_rx_i,
  input wire logic [15:0] tx_page_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire npt = adr_i == anp_pkg::NPT_ADDR;
  wire wr  = ack_o && we_i && npt;
  ack_time_a: assert property ($rose(stb_i) && cyc_i |=> ack_o) else $error("late ack");
  rsvd_rd_a: assert property (ack_o && npt |-> !dat_o[14]) else $error("bit 14 read");
  rsvd_tx_a: assert property (!tx_page_o[14]) else $error("bit 14 sent");
  hi_wr_a: assert property (wr && sel_i[1] |-> ##2 tx_page_o[15:12] == {$past(dat_i[15], 2), 1'b0, $past(dat_i[13:12], 2)})
    else $error("flags");
  code_wr_a: assert property (wr && sel_i[0] |-> ##2 tx_page_o[7:0] == $past(dat_i[7:0], 2)) else $error("code");
  tog_flip_a: assert property (page_sent_i |-> ##2 tx_page_o[11] != $past(tx_page_o[11], 2))
    else $error("toggle");
  tog_hold_a: assert property ($changed(tx_page_o[11]) |-> $past(page_sent_i, 2)) else $error("toggle moved");
  rst_word_a: assert property (disable iff (1'b0) rst_i |=> tx_page_o == anp_pkg::NPT_RESET)
    else $error("reset word");
  cover property (wr);
  cover property (page_sent_i);
  cover property (page_rx_i);
endmodule : anp_chk
bind anp_next_page_tx anp_chk anp_chk_inst (.*);

// ===== anp_partner.sv
// Model of the remote arbitration: sends a page, then one arrives
`timescale 1ns/1ps
module anp_partner (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic slow_i,
  output logic      sent_o,
  output logic      rx_o
);
  logic [3:0] sh_q = 4'h0;
  always_ff @(posedge clk_i) sh_q <= {sh_q[2:0], go_i};
  assign sent_o = sh_q[0];
  assign rx_o   = slow_i ? sh_q[3] : sh_q[1];
endmodule : anp_partner

// ===== anp_next_page_tx_bench.sv
// Testbench for the next page transmit block
`timescale 1ns/1ps
module anp_next_page_tx_bench;
  logic        clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we_i = 1'b0, go = 1'b0, slow = 1'b0;
  logic        ack_o, page_sent_i, page_rx_i;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000, dat_o, r;
  logic [15:0] tx_page_o;
  int          fail_count = 0, checks = 0;
  always #5 clk_i = ~clk_i;
  anp_next_page_tx anp_next_page_tx_inst (.cyc_i(req), .stb_i(req), .sel_i(4'h3), .*);
  anp_partner anp_partner_inst (.clk_i, .go_i(go), .slow_i(slow), .sent_o(page_sent_i), .rx_o(page_rx_i));
  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    req   <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      fail_count++;
      stop_test();
    end
    r = dat_o;
    req <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000);
    checks++;
    if (r !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, r);
    end
  endtask : rd
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(anp_pkg::NPT_ADDR, 32'h0000_2001, "reset");
    rd(8'h40, 32'h0000_0000, "unmapped");
    $display("reset test done");
    bus(1'b1, anp_pkg::NPT_ADDR, 32'hFFFF_FFFF);
    rd(anp_pkg::NPT_ADDR, 32'h0000_B7FF, "ones");
    bus(1'b1, anp_pkg::NPT_ADDR, 32'h0000_4800);
    rd(anp_pkg::NPT_ADDR, 32'h0000_0000, "zeros");
    $display("write test done");
    for (int i = 0; i < 2; i++) begin
      slow <= i[0];
      go   <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd(anp_pkg::NPT_ADDR, i ? 32'h0000_0000 : 32'h0000_0800, "toggle");
      rd(anp_pkg::PAGE_STS_ADDR, 32'h0000_0001, "rx set");
      rd(anp_pkg::PAGE_STS_ADDR, 32'h0000_0000, "rx clear");
    end
    $display("toggle test done");
    stop_test();
  end
endmodule : anp_next_page_tx_bench
